// file: include/serial_output_mode_defines.svh
// Offsets, field positions, reset values and frame counts of the output mode block
`ifndef SERIAL_OUTPUT_MODE_DEFINES_SVH
`define SERIAL_OUTPUT_MODE_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FMT_SELECT_ADDR     13'h0021
`define CM_CONTROL_ADDR     13'h0102
`define FMT_SELECT_RESET    8'h32
`define CM_PD_BIT           3
`define CM_CONTROL_RESET    8'h00

// ****************************************************************
// Serial control frame layout
// ****************************************************************
`define FRAME_RW_BIT        15
`define FRAME_INSTR_LAST    5'h0F
`define FRAME_DATA_LAST     5'h17

// ****************************************************************
// Sample stream
// ****************************************************************
`define SAMPLE_WIDTH        12
`define STREAM_DEPTH        16

`endif

// file: include/serial_output_mode_pkg.sv
// Types shared by the output mode block
`default_nettype none
package serial_output_mode_pkg;

  // Lane and rate arrangement of the serializer
  typedef enum logic [2:0] {
    LANE_DDR_BYTEWISE,
    LANE_DDR_BITWISE,
    LANE_SDR_BYTEWISE,
    LANE_SDR_BITWISE,
    LANE_DDR_ONE
  } lane_mode_t;

  // Decoded output mode; clock multiple is in half units of the sample rate
  typedef struct packed {
    logic       code_valid;
    logic       word_is_12;
    logic       frame_2x;
    lane_mode_t lane_mode;
    logic [4:0] clk_mult_half;
  } fmt_mode_t;

  // Configuration word passed from the serial port domain
  typedef struct packed {
    logic [7:0] fmt_code;
    logic       cm_powerdown;
  } cfg_word_t;

endpackage : serial_output_mode_pkg

`default_nettype wire

// file: rtl/sample_fifo.sv
// Sample FIFO with registered read data and registered ready
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,   // Core clock
  input  wire logic             rst,        // Async reset, high
  input  wire logic [WIDTH-1:0] in_data,    // Word to store
  input  wire logic             in_valid,   // Word offered
  output logic                  in_ready,   // Room for a word
  output logic      [WIDTH-1:0] out_data,   // Oldest word
  output logic                  out_valid,  // Oldest word present
  input  wire logic             out_ready   // Drain accepts
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             rdy_r, rdy_nxt;
  logic             vld_r, vld_nxt;
  logic [WIDTH-1:0] dat_r, dat_nxt;
  logic             push, pop;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Ready is computed from the next count so that full is never overrun
  always_comb begin
    push       = in_valid && rdy_r;
    pop        = (cnt_r != '0) && (!vld_r || out_ready);
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    cnt_nxt    = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    rdy_nxt    = (cnt_nxt != (AW+1)'(DEPTH));
    vld_nxt    = pop ? 1'b1 : (out_ready ? 1'b0 : vld_r);
    dat_nxt    = pop ? mem_r[rd_ptr_r] : dat_r;
  end

  // Storage array, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, count and output stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      rdy_r    <= 1'b1;
      vld_r    <= 1'b0;
      dat_r    <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r    <= cnt_nxt;
      rdy_r    <= rdy_nxt;
      vld_r    <= vld_nxt;
      dat_r    <= dat_nxt;
    end
  end

  assign in_ready  = rdy_r;
  assign out_valid = vld_r;
  assign out_data  = dat_r;

endmodule : sample_fifo

`default_nettype wire

// file: rtl/serial_output_mode_select.sv
// Output mode select: serial control port, mode decode and sample stream
`timescale 1ns/1ps
`default_nettype none
`include "serial_output_mode_defines.svh"

module serial_output_mode_select (
  input  wire logic                              core_clk,        // Sample-side clock
  input  wire logic                              rst,             // Async reset, high
  input  wire logic                              spi_clk,         // Serial control clock
  input  wire logic                              port_select_low, // Frame select, low
  input  wire logic                              sdio_in,         // Serial data in
  output logic                                   sdio_out,        // Serial data out
  output logic                                   sdio_oe_n,       // Drive enable, low
  output serial_output_mode_pkg::fmt_mode_t      mode,            // Decoded output mode
  output logic                                   mode_invalid,    // Unlisted code held
  output logic                                   cm_powerdown,    // Generator off
  input  wire logic [`SAMPLE_WIDTH-1:0]          sample_data,     // Converted sample
  input  wire logic                              sample_valid,    // Sample offered
  output logic                                   sample_ready,    // Stream has room
  output logic      [`SAMPLE_WIDTH-1:0]          out_word,        // Formatted word
  output logic                                   out_valid,       // Word present
  input  wire logic                              out_ready        // Capture accepts
);

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  function automatic serial_output_mode_pkg::fmt_mode_t decode_mode(input logic [7:0] code);
    serial_output_mode_pkg::fmt_mode_t m;
    logic                              ten;
    m             = '0;
    ten           = code[0];
    m.word_is_12  = !ten;
    m.frame_2x    = code[2];
    // Bit 3 set is never a listed code, and one-lane exists only as 0x42/0x43
    m.code_valid  = ((code[1] == 1'b1) && (code[3] == 1'b0) && (code[7:4] <= 4'h3)) ||
                    (code[7:1] == 7'h21);
    case (code[7:4])
      4'h3: m.lane_mode = serial_output_mode_pkg::LANE_DDR_BYTEWISE;
      4'h2: m.lane_mode = serial_output_mode_pkg::LANE_DDR_BITWISE;
      4'h1: m.lane_mode = serial_output_mode_pkg::LANE_SDR_BYTEWISE;
      4'h0: m.lane_mode = serial_output_mode_pkg::LANE_SDR_BITWISE;
      default: m.lane_mode = serial_output_mode_pkg::LANE_DDR_ONE;
    endcase
    // Two-lane DDR runs at half the rate of SDR or one-lane DDR
    if (m.lane_mode == serial_output_mode_pkg::LANE_DDR_BYTEWISE ||
        m.lane_mode == serial_output_mode_pkg::LANE_DDR_BITWISE) begin
      m.clk_mult_half = ten ? 5'h05 : 5'h06;
    end else begin
      m.clk_mult_half = ten ? 5'h0A : 5'h0C;
    end
    if (!m.code_valid) begin
      m.clk_mult_half = 5'h00;
    end
    return m;
  endfunction : decode_mode

  // ****************************************************************
  // Serial control port, spi_clk domain
  // ****************************************************************
  typedef enum logic [1:0] {SP_INSTR, SP_WRITE, SP_READ, SP_DONE} sp_state_t;

  sp_state_t                          sp_state_r, sp_state_nxt;
  logic [4:0]                         bit_cnt_r, bit_cnt_nxt;
  logic [15:0]                        shift_r, shift_nxt;
  logic [12:0]                        addr_r, addr_nxt;
  logic [7:0]                         rd_shift_r, rd_shift_nxt;
  logic                               sdo_r, sdo_nxt;
  logic                               oe_n_r, oe_n_nxt;
  logic                               frame_rst;
  logic                               commit;
  logic [7:0]                         rd_byte;
  serial_output_mode_pkg::cfg_word_t  cfg_r, cfg_nxt;
  logic                               upd_tgl_r, upd_tgl_nxt;

  // Frame select ends a frame asynchronously, since sclk stops outside frames
  assign frame_rst = rst | port_select_low;

  // Readback mux; unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input logic [12:0] a,
                                          input serial_output_mode_pkg::cfg_word_t c);
    logic [7:0] d;
    d = 8'h00;
    if (a == `FMT_SELECT_ADDR) begin
      d = c.fmt_code;
    end else if (a == `CM_CONTROL_ADDR) begin
      d[`CM_PD_BIT] = c.cm_powerdown;
    end
    return d;
  endfunction : read_reg

  // Frame sequencing: 16-bit instruction then one data byte
  always_comb begin
    sp_state_nxt = sp_state_r;
    bit_cnt_nxt  = bit_cnt_r + 5'h01;
    shift_nxt    = {shift_r[14:0], sdio_in};
    addr_nxt     = addr_r;
    rd_shift_nxt = rd_shift_r;
    sdo_nxt      = sdo_r;
    oe_n_nxt     = oe_n_r;
    commit       = 1'b0;
    rd_byte      = 8'h00;
    case (sp_state_r)
      SP_INSTR: begin
        if (bit_cnt_r == `FRAME_INSTR_LAST) begin
          addr_nxt = shift_nxt[12:0];
          if (shift_nxt[`FRAME_RW_BIT]) begin
            sp_state_nxt = SP_READ;
            rd_byte      = read_reg(shift_nxt[12:0], cfg_r);
            rd_shift_nxt = {rd_byte[6:0], 1'b0};
            sdo_nxt      = rd_byte[7];
            oe_n_nxt     = 1'b0;
          end else begin
            sp_state_nxt = SP_WRITE;
          end
        end
      end
      SP_WRITE: begin
        if (bit_cnt_r == `FRAME_DATA_LAST) begin
          commit       = 1'b1;
          sp_state_nxt = SP_DONE;
        end
      end
      SP_READ: begin
        sdo_nxt      = rd_shift_r[7];
        rd_shift_nxt = {rd_shift_r[6:0], 1'b0};
        if (bit_cnt_r == `FRAME_DATA_LAST) begin
          oe_n_nxt     = 1'b1;
          sp_state_nxt = SP_DONE;
        end
      end
      SP_DONE: begin
        bit_cnt_nxt = bit_cnt_r;                // Extra bytes are ignored
      end
      default: begin
        sp_state_nxt = SP_DONE;
      end
    endcase
  end

  // Frame state, cleared whenever the frame select is high
  always_ff @(posedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      sp_state_r <= SP_INSTR;
      bit_cnt_r  <= 5'h00;
      shift_r    <= 16'h0000;
      addr_r     <= 13'h0000;
      rd_shift_r <= 8'h00;
      sdo_r      <= 1'b0;
      oe_n_r     <= 1'b1;
    end else begin
      sp_state_r <= sp_state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      addr_r     <= addr_nxt;
      rd_shift_r <= rd_shift_nxt;
      sdo_r      <= sdo_nxt;
      oe_n_r     <= oe_n_nxt;
    end
  end

  // Register write on the last data edge; toggle tells the core side
  always_comb begin
    cfg_nxt     = cfg_r;
    upd_tgl_nxt = upd_tgl_r;
    if (commit && addr_r == `FMT_SELECT_ADDR) begin
      cfg_nxt.fmt_code = shift_nxt[7:0];
      upd_tgl_nxt      = !upd_tgl_r;
    end else if (commit && addr_r == `CM_CONTROL_ADDR) begin
      cfg_nxt.cm_powerdown = shift_nxt[`CM_PD_BIT];
      upd_tgl_nxt          = !upd_tgl_r;
    end
  end

  // Registers survive frame ends; only the main reset clears them
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      cfg_r     <= {`FMT_SELECT_RESET, 1'b0};
      upd_tgl_r <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      upd_tgl_r <= upd_tgl_nxt;
    end
  end

  assign sdio_out  = sdo_r;
  assign sdio_oe_n = oe_n_r;

  // ****************************************************************
  // Configuration crossing and mode outputs, core_clk domain
  // ****************************************************************
  // The word is stable for many serial edges after the toggle, so it is
  // sampled only once the synchronised toggle shows a change.
  logic                              tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic                              tgl_s1_nxt, tgl_s2_nxt, tgl_s3_nxt;
  serial_output_mode_pkg::fmt_mode_t mode_r, mode_nxt;
  logic                              inval_r, inval_nxt;
  logic                              cmpd_r, cmpd_nxt;

  always_comb begin
    tgl_s1_nxt = upd_tgl_r;
    tgl_s2_nxt = tgl_s1_r;
    tgl_s3_nxt = tgl_s2_r;
    mode_nxt   = mode_r;
    inval_nxt  = inval_r;
    cmpd_nxt   = cmpd_r;
    if (tgl_s2_r != tgl_s3_r) begin
      mode_nxt  = decode_mode(cfg_r.fmt_code);
      inval_nxt = !mode_nxt.code_valid;
      cmpd_nxt  = cfg_r.cm_powerdown;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      mode_r   <= decode_mode(`FMT_SELECT_RESET);
      inval_r  <= 1'b0;
      cmpd_r   <= 1'b0;
    end else begin
      tgl_s1_r <= tgl_s1_nxt;
      tgl_s2_r <= tgl_s2_nxt;
      tgl_s3_r <= tgl_s3_nxt;
      mode_r   <= mode_nxt;
      inval_r  <= inval_nxt;
      cmpd_r   <= cmpd_nxt;
    end
  end

  assign mode         = mode_r;
  assign mode_invalid = inval_r;
  assign cm_powerdown = cmpd_r;

  // ****************************************************************
  // Sample stream
  // ****************************************************************
  // In 10-bit mode the two low bits are dropped, so the word is MSB aligned
  logic [`SAMPLE_WIDTH-1:0] fmt_word;

  always_comb begin
    fmt_word = sample_data;
    if (!mode_r.word_is_12) begin
      fmt_word = {sample_data[`SAMPLE_WIDTH-1:2], 2'b00};
    end
  end

  sample_fifo #(
    .WIDTH (`SAMPLE_WIDTH),
    .DEPTH (`STREAM_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (fmt_word),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (out_word),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );

endmodule : serial_output_mode_select

`default_nettype wire

// file: verif/serial_output_mode_properties.sv
// Port-level checks of the output mode block
`timescale 1ns/1ps
`default_nettype none
`include "serial_output_mode_defines.svh"
module mode_checker (
  input wire logic                          core_clk,        // Core clock
  input wire logic                          rst,             // Async reset, high
  input wire logic                          spi_clk,         // Serial clock
  input wire logic                          port_select_low, // Frame select, low
  input wire logic                          sdio_oe_n,       // Drive enable, low
  input wire serial_output_mode_pkg::fmt_mode_t mode,        // Decoded mode
  input wire logic                          mode_invalid,    // Unlisted code
  input wire logic                          cm_powerdown,    // Generator off
  input wire logic                          sample_ready,    // Stream room
  input wire logic [`SAMPLE_WIDTH-1:0]      out_word,        // Head word
  input wire logic                          out_valid,       // Head present
  input wire logic                          out_ready        // Capture accepts
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic [3:0] quiet_r;
  logic [3:0] quiet_nxt;
  logic [4:0] half_exp;
  logic       ddr_two;
  // Core cycles since the port was last selected; saturates
  always_comb begin
    quiet_nxt = port_select_low ? ((quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1) : 4'h0;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) quiet_r <= 4'hF;
    else quiet_r <= quiet_nxt;
  end
  // Clock multiple in half units; DDR two-lane halves the serial rate
  assign ddr_two = (mode.lane_mode == serial_output_mode_pkg::LANE_DDR_BYTEWISE) ||
                   (mode.lane_mode == serial_output_mode_pkg::LANE_DDR_BITWISE);
  assign half_exp = ddr_two ? (mode.word_is_12 ? 5'h06 : 5'h05)
                            : (mode.word_is_12 ? 5'h0C : 5'h0A);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  reset_mode_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst) |-> mode == {3'b110, serial_output_mode_pkg::LANE_DDR_BYTEWISE, 5'h06})
    else $error("mode after reset wrong");
  flag_match_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_invalid == !mode.code_valid) else $error("invalid flag mismatch");
  invalid_clk_a: assert property (@(posedge core_clk) disable iff (rst)
    mode_invalid |-> mode.clk_mult_half == 5'h00) else $error("invalid code has clock");
  clk_multiple_a: assert property (@(posedge core_clk) disable iff (rst)
    mode.code_valid |-> mode.clk_mult_half == half_exp) else $error("clock multiple wrong");
  one_lane_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode.code_valid && mode.lane_mode == serial_output_mode_pkg::LANE_DDR_ONE) |->
    !mode.frame_2x) else $error("one-lane mode in 2x frame");
  mode_write_a: assert property (@(posedge core_clk) disable iff (rst)
    !$stable(mode) |-> quiet_r < 4'h6) else $error("mode changed outside a write");
  cm_write_a: assert property (@(posedge core_clk) disable iff (rst)
    !$stable(cm_powerdown) |-> quiet_r < 4'h6) else $error("power-down changed idle");
  head_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(out_word)) else $error("head dropped");
  // Core clock here, since the serial clock stops whenever the port is deselected
  idle_release_a: assert property (@(posedge core_clk) disable iff (rst)
    port_select_low |-> sdio_oe_n) else $error("drives data while deselected");
  // Main scenarios
  cover property (@(posedge core_clk) disable iff (rst) $rose(mode_invalid));
  cover property (@(posedge core_clk) disable iff (rst) $rose(cm_powerdown));
  cover property (@(posedge core_clk) disable iff (rst) $fell(sample_ready));
  cover property (@(posedge spi_clk) disable iff (rst) !sdio_oe_n);
endmodule : mode_checker

bind serial_output_mode_select mode_checker u_chk (.core_clk, .rst, .spi_clk,
  .port_select_low, .sdio_oe_n, .mode, .mode_invalid, .cm_powerdown, .sample_ready,
  .out_word, .out_valid, .out_ready);
`default_nettype wire

// file: verif/capture_model.sv
// Capture logic model that drains the formatted word stream
`timescale 1ns/1ps
`default_nettype none
`include "serial_output_mode_defines.svh"
module capture_model (
  input  wire logic [`SAMPLE_WIDTH-1:0] out_word,  // Word from block
  input  wire logic                     core_clk,  // Core clock
  input  wire logic                     rst,       // Async reset, high
  input  wire logic                     out_valid, // Word present
  input  wire logic                     hold,      // Stall from bench
  output var  logic                     out_ready  // Accept
);
  logic [`SAMPLE_WIDTH-1:0] got [$];
  // Registered ready, so a stall lands one cycle late like real capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !hold;
      if (out_valid && out_ready) got.push_back(out_word);
    end
  end
endmodule : capture_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the output mode block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, rst, spi_clk, port_select_low, sdio, tb_bit, tb_en, sample_valid, hold;
  logic sdio_out, sdio_oe_n, mode_invalid, cm_powerdown, sample_ready, out_valid, out_ready;
  logic [11:0] sample_data, out_word;
  serial_output_mode_pkg::fmt_mode_t mode;
  int errors, check_count;
  logic [7:0] codes [23] = '{8'h32, 8'h22, 8'h12, 8'h02, 8'h36, 8'h26, 8'h16, 8'h06,
    8'h42, 8'h33, 8'h23, 8'h13, 8'h03, 8'h37, 8'h27, 8'h17, 8'h07, 8'h43,
    8'h00, 8'h3A, 8'h44, 8'h52, 8'h46};
  // Shared data wire; the pin has a pull-down when nobody drives
  assign sdio = !sdio_oe_n ? sdio_out : (tb_en ? tb_bit : 1'b0);
  serial_output_mode_select DUT (.core_clk, .rst, .spi_clk, .port_select_low,
    .sdio_in(sdio), .sdio_out, .sdio_oe_n, .mode, .mode_invalid, .cm_powerdown,
    .sample_data, .sample_valid, .sample_ready, .out_word, .out_valid, .out_ready);
  capture_model cap (.core_clk, .rst, .out_word, .out_valid, .hold, .out_ready);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic serial_output_mode_pkg::fmt_mode_t exp_mode(input logic [7:0] c);
    serial_output_mode_pkg::fmt_mode_t m;
    logic two;
    two = c[7:4] <= 4'h3;
    m.code_valid = c[1] && !c[3] && (two || c[7:2] == 6'h10);
    m.word_is_12 = !c[0];
    m.frame_2x = c[2];
    m.lane_mode = two ? serial_output_mode_pkg::lane_mode_t'(3'd3 - c[6:4])
                      : serial_output_mode_pkg::LANE_DDR_ONE;
    m.clk_mult_half = (two && c[5]) ? (c[0] ? 5'h05 : 5'h06) : (c[0] ? 5'h0A : 5'h0C);
    return m;
  endfunction : exp_mode
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic test_done;
    $display("TB: errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // One serial frame of nb bits; outside frames the link clock runs only during reset
  task automatic frame(input logic [23:0] w, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    port_select_low <= 1'b0;
    // Odd offset keeps every serial edge off the core clock edges
    #43;
    for (int i = 0; i < nb; i++) begin
      tb_bit = w[23-i];
      tb_en = !(w[23] && i > 15);
      #80 spi_clk = 1'b1;
      #80 spi_clk = 1'b0;
      if (i > 14 && i < 23) rd[22-i] = sdio;
    end
    #80 port_select_low = 1'b1;
    tb_en = 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : frame
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    frame({3'b000, a, d}, 24, r);
  endtask : wr
  task automatic chk_rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] r;
    frame({3'b100, a, 8'h00}, 24, r);
    cmp("readback", {8'h00, e}, {8'h00, r});
  endtask : chk_rd
  task automatic chk_mode(input logic [7:0] c);
    serial_output_mode_pkg::fmt_mode_t m;
    m = exp_mode(c);
    cmp("mode_invalid", {15'h0, !m.code_valid}, {15'h0, mode_invalid});
    if (m.code_valid) cmp("mode", {5'h00, m}, {5'h00, mode});
    else cmp("clk_mult_half", 16'h0000, {11'h0, mode.clk_mult_half});
  endtask : chk_mode
  // Fill until refused with capture stalled, then drain and compare
  task automatic stream(input logic [11:0] mask);
    int n;
    n = 0;
    hold <= 1'b1;
    sample_valid <= 1'b1;
    sample_data <= 12'h5A7;
    repeat (30) begin
      @(posedge core_clk);
      if (sample_ready) begin
        n++;
        sample_data <= 12'h5A7 + 12'(n * 37);
      end
    end
    sample_valid <= 1'b0;
    hold <= 1'b0;
    cmp("accepted", 16'd17, 16'(n));
    for (int k = 0; k < 80 && cap.got.size() < n; k++) @(posedge core_clk);
    if (cap.got.size() != n) begin
      errors++;
      test_done();
    end
    for (int k = 0; k < n; k++) cmp("word", {4'h0, (12'h5A7 + 12'(k * 37)) & mask},
      {4'h0, cap.got[k]});
    cap.got.delete();
  endtask : stream
  // ****************************************************************
  // Clock and sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    #7;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    logic [7:0] r;
    {rst, port_select_low, tb_en} = 3'b111;
    {spi_clk, tb_bit, sample_valid, hold, sample_data} = '0;
    errors = 0;
    check_count = 0;
    repeat (4) begin
      @(posedge core_clk);
      spi_clk = ~spi_clk;
    end
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk_mode(8'h32);
    chk_rd(13'h0021, 8'h32);
    chk_rd(13'h0102, 8'h00);
    wr(13'h0102, 8'h08);
    cmp("cm_powerdown", 16'h0001, {15'h0, cm_powerdown});
    chk_rd(13'h0102, 8'h08);
    wr(13'h0102, 8'hF7);
    cmp("cm_powerdown", 16'h0000, {15'h0, cm_powerdown});
    chk_rd(13'h0102, 8'h00);
    foreach (codes[i]) begin
      wr(13'h0021, codes[i]);
      chk_mode(codes[i]);
      chk_rd(13'h0021, codes[i]);
    end
    wr(13'h0021, 8'h33);
    frame({3'b000, 13'h0021, 8'h32}, 20, r);
    wr(13'h0100, 8'h32);
    chk_mode(8'h33);
    chk_rd(13'h0100, 8'h00);
    stream(12'hFFC);
    wr(13'h0021, 8'h32);
    stream(12'hFFF);
    test_done();
  end
endmodule : testbench
`default_nettype wire
